// File: cmb_msg_buffer.sv
// Purpose: Transmit queue, two-stage receive FIFO and CAN port pins
// Assumes: A bit-level protocol engine on core_clk_in drives the frame strobes
// Notes: Engine writes every byte of a frame before it pulses the frame-good strobe
`timescale 1ns/1ps
`include "cmb_params.svh"

module cmb_msg_buffer #(
   parameter int NUM_TXBUF = `CMB_NUM_TXBUF,
   parameter int MSG_BYTES = `CMB_MSG_BYTES
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   // CAN port pins
   input wire logic bus_receive_pin_in,
   output logic bus_transmit_pin_out,
   input wire logic [`CMB_GP_W-1:0] gp_pin_in,
   output logic [`CMB_GP_W-1:0] gp_pin_out,
   output logic [`CMB_GP_W-1:0] gp_pin_oe_n_out,
   input wire logic [`CMB_GP_W-1:0] gp_data_in,
   input wire logic [`CMB_GP_W-1:0] gp_dir_in,
   output logic [`CMB_PORT_W-1:0] port_read_out,
   input wire logic loopback_in,
   // Protocol engine side
   output logic engine_rx_bit_out,
   input wire logic engine_tx_bit_in,
   output logic tx_request_out,
   output logic [1:0] tx_buf_sel_out,
   input wire logic tx_start_in,
   input wire logic tx_done_in,
   input wire logic arb_lost_in,
   input wire logic [`CMB_IDX_W-1:0] tx_rd_idx_in,
   output logic [7:0] tx_rd_data_out,
   input wire logic rx_byte_we_in,
   input wire logic [`CMB_IDX_W-1:0] rx_byte_idx_in,
   input wire logic [7:0] rx_byte_in,
   input wire logic rx_frame_ok_in,
   input wire logic rx_accept_in,
   output logic rx_ack_en_out,
   // Host side
   input wire logic tx_wr_in,
   input wire logic [1:0] tx_wr_buf_in,
   input wire logic [`CMB_IDX_W-1:0] tx_wr_idx_in,
   input wire logic [7:0] tx_wr_data_in,
   input wire logic tx_prio_wr_in,
   input wire logic [`CMB_PRIO_W-1:0] tx_prio_in,
   input wire logic [NUM_TXBUF-1:0] tx_ready_set_in,
   output logic [NUM_TXBUF-1:0] tx_empty_out,
   input wire logic [`CMB_IDX_W-1:0] fg_rd_idx_in,
   output logic [7:0] fg_rd_data_out,
   output logic [`CMB_FLAG_W-1:0] receiver_flag_register_out,
   input wire logic [`CMB_FLAG_W-1:0] flag_clr_in,
   input wire logic rx_int_en_in,
   input wire logic ovr_int_en_in,
   output logic rx_int_out,
   output logic ovr_int_out
);

   //***************************************************************
   // Pins
   //***************************************************************
   logic rx_meta_q, rx_sync_q, tx_pin_q;
   logic [`CMB_GP_W-1:0] gp_meta_q, gp_sync_q;

   // Pins come from outside the clock domain: two flops first
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_meta_q <= `CMB_RECESSIVE;
         rx_sync_q <= `CMB_RECESSIVE;
         gp_meta_q <= '0;
         gp_sync_q <= '0;
      end else begin
         rx_meta_q <= bus_receive_pin_in;
         rx_sync_q <= rx_meta_q;
         gp_meta_q <= gp_pin_in;
         gp_sync_q <= gp_meta_q;
      end
   end

   // Engine bit: 0 dominant, 1 recessive; loop-back keeps the bus recessive
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_pin_q <= `CMB_RECESSIVE;
      end else begin
         tx_pin_q <= loopback_in ? `CMB_RECESSIVE : engine_tx_bit_in;
      end
   end
   assign bus_transmit_pin_out = tx_pin_q;
   assign engine_rx_bit_out = loopback_in ? engine_tx_bit_in : rx_sync_q;

   // General-purpose pins; enable low while driving
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         gp_pin_out <= '0;
         gp_pin_oe_n_out <= '1;
         port_read_out <= '0;
      end else begin
         gp_pin_out <= gp_data_in;
         gp_pin_oe_n_out <= ~gp_dir_in;
         port_read_out[`CMB_PIN_RX] <= rx_sync_q;
         port_read_out[`CMB_PIN_TX] <= tx_pin_q;
         port_read_out[`CMB_PORT_W-1:`CMB_PIN_GP] <=
            (gp_dir_in & gp_data_in) | (~gp_dir_in & gp_sync_q);
      end
   end

   //***************************************************************
   // Transmit buffers and scheduler
   //***************************************************************
   logic [7:0] tx_mem [NUM_TXBUF][MSG_BYTES];
   logic [`CMB_PRIO_W-1:0] prio_q [NUM_TXBUF];
   logic [NUM_TXBUF-1:0] ready_q;
   logic [1:0] sel_q, best;
   cmb_pkg::cmb_tx_e tx_state_q;
   logic sending;

   // Lowest priority value wins, lower index breaks a tie
   always_comb begin
      best = '0;
      for (int i = 1; i < NUM_TXBUF; i++) begin
         if (ready_q[i] && (!ready_q[best] || prio_q[i] < prio_q[best])) begin
            best = 2'(i);
         end
      end
   end

   assign sending = (tx_state_q == cmb_pkg::CMB_TX_SEND);
   assign tx_request_out = (|ready_q) && !sending;
   assign tx_buf_sel_out = sending ? sel_q : best;
   assign tx_empty_out = ~ready_q;

   // Host loads only buffers that are not queued
   always_ff @(posedge core_clk_in) begin
      if (tx_wr_in && !ready_q[tx_wr_buf_in]) begin
         tx_mem[tx_wr_buf_in][tx_wr_idx_in] <= tx_wr_data_in;
      end
      tx_rd_data_out <= tx_mem[tx_buf_sel_out][tx_rd_idx_in];
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < NUM_TXBUF; i++) begin
            prio_q[i] <= '0;
         end
      end else if (tx_prio_wr_in && !ready_q[tx_wr_buf_in]) begin
         prio_q[tx_wr_buf_in] <= tx_prio_in;
      end
   end

   // Sent buffer returns to empty; lost arbitration leaves it queued
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_state_q <= cmb_pkg::CMB_TX_IDLE;
         sel_q <= '0;
         ready_q <= '0;
      end else begin
         unique case (tx_state_q)
            cmb_pkg::CMB_TX_IDLE: begin
               if (tx_start_in && (|ready_q)) begin
                  sel_q <= best;
                  tx_state_q <= cmb_pkg::CMB_TX_SEND;
               end
            end
            cmb_pkg::CMB_TX_SEND: begin
               if (tx_done_in || arb_lost_in) begin
                  tx_state_q <= cmb_pkg::CMB_TX_IDLE;
               end
            end
         endcase
         for (int i = 0; i < NUM_TXBUF; i++) begin
            if (sending && tx_done_in && sel_q == 2'(i)) begin
               ready_q[i] <= 1'b0;
            end else if (tx_ready_set_in[i]) begin
               ready_q[i] <= 1'b1;
            end
         end
      end
   end

   //***************************************************************
   // Receive FIFO
   //***************************************************************
   logic [7:0] bg_mem [MSG_BYTES];
   logic [7:0] fg_mem [MSG_BYTES];
   logic bg_held_q, rxf_q, ovr_q;
   logic own_frame, deliver, copy;

   // Own frame only counts while still sending, not after a lost arbitration
   assign own_frame = sending && !loopback_in;
   assign rx_ack_en_out = !own_frame;
   assign deliver = rx_frame_ok_in && rx_accept_in && !own_frame;
   assign copy = bg_held_q && !rxf_q;

   // Background takes every frame unless it holds a waiting message
   always_ff @(posedge core_clk_in) begin
      if (rx_byte_we_in && !bg_held_q) begin
         bg_mem[rx_byte_idx_in] <= rx_byte_in;
      end
   end

   // Whole-stage copy in one cycle keeps the host window consistent
   always_ff @(posedge core_clk_in) begin
      if (copy) begin
         fg_mem <= bg_mem;
      end
      fg_rd_data_out <= fg_mem[fg_rd_idx_in];
   end

   // Accepted frame waits in background until foreground frees
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         bg_held_q <= 1'b0;
      end else if (copy) begin
         bg_held_q <= 1'b0;
      end else if (deliver) begin
         bg_held_q <= 1'b1;
      end
   end

   // Set wins over a same-cycle clear
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rxf_q <= 1'b0;
      end else if (copy) begin
         rxf_q <= 1'b1;
      end else if (flag_clr_in[`CMB_FLAG_RXF]) begin
         rxf_q <= 1'b0;
      end
   end

   // Third accepted frame while both stages hold messages
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ovr_q <= 1'b0;
      end else if (deliver && bg_held_q && rxf_q) begin
         ovr_q <= 1'b1;
      end else if (flag_clr_in[`CMB_FLAG_OVR]) begin
         ovr_q <= 1'b0;
      end
   end

   assign receiver_flag_register_out = {ovr_q, rxf_q};
   assign rx_int_out = rxf_q && rx_int_en_in;
   assign ovr_int_out = ovr_q && ovr_int_en_in;

   //***************************************************************
   // Assertions
   //***************************************************************
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   a_copy_sets_flag: assert property (copy |=> rxf_q && !bg_held_q)
      else $error("copy did not set receive-full");
   a_copy_only_clear: assert property (rxf_q |=> $stable(fg_mem[0]))
      else $error("foreground changed while receive-full set");
   a_own_no_deliver: assert property (
      rx_frame_ok_in && sending && !loopback_in && !bg_held_q |=> !bg_held_q)
      else $error("own frame delivered");
   a_loop_deliver: assert property (
      rx_frame_ok_in && rx_accept_in && loopback_in && !bg_held_q |=> ##1 rxf_q)
      else $error("loop-back frame not delivered");
   a_overrun_flag: assert property (
      deliver && bg_held_q && rxf_q |=> ovr_q && bg_held_q)
      else $error("overrun not flagged");
   a_bg_frozen: assert property (bg_held_q && rxf_q |=> $stable(bg_mem[0]))
      else $error("held background changed");
   a_rx_int_mask: assert property (rx_int_out |-> rx_int_en_in && rxf_q)
      else $error("receive interrupt while masked");
   a_tx_rearb: assert property (
      sending && tx_done_in && (|(ready_q & ~(NUM_TXBUF'(1) << sel_q)))
      |=> tx_request_out)
      else $error("no re-arbitration after frame");
   // Chosen buffer must not lose to any buffer that was queued at the start
   a_tx_prio: assert property (
      tx_start_in && !sending && (|ready_q) |=>
      (!$past(ready_q[0]) || prio_q[sel_q] <= prio_q[0]) &&
      (!$past(ready_q[1]) || prio_q[sel_q] <= prio_q[1]) &&
      (!$past(ready_q[2]) || prio_q[sel_q] <= prio_q[2]))
      else $error("lower priority buffer chosen");
   a_tx_pin_level: assert property (loopback_in |=> bus_transmit_pin_out)
      else $error("transmit pin dominant in loop-back");
   a_gp_drive: assert property (gp_dir_in[0] |=> !gp_pin_oe_n_out[0])
      else $error("output pin not driven");
   a_clear_ovr: assert property (
      ovr_q && flag_clr_in[`CMB_FLAG_OVR] && !deliver |=> !ovr_q)
      else $error("overrun not cleared");

endmodule // cmb_msg_buffer

// File: cmb_params.svh
// Purpose: Constants for the CAN message buffering block
// Assumes: Included by its bare name
// Notes: Bit positions, sizes and bus levels only
`ifndef CMB_PARAMS_SVH
`define CMB_PARAMS_SVH
`define CMB_NUM_TXBUF 3
`define CMB_MSG_BYTES 13
`define CMB_IDX_W 4
`define CMB_PRIO_W 8
`define CMB_PORT_W 8
`define CMB_GP_W 6
`define CMB_PIN_RX 0
`define CMB_PIN_TX 1
`define CMB_PIN_GP 2
`define CMB_FLAG_RXF 0
`define CMB_FLAG_OVR 1
`define CMB_FLAG_W 2
`define CMB_RECESSIVE 1'b1
`define CMB_DOMINANT 1'b0
`endif

// File: cmb_pkg.sv
// Purpose: Types for the CAN message buffering block
// Assumes: Nothing
// Notes: Transmit scheduler states, one-hot
package cmb_pkg;
   typedef enum logic [1:0] {
      CMB_TX_IDLE = 2'b01,
      CMB_TX_SEND = 2'b10
   } cmb_tx_e;
endpackage

// File: cmb_can_bus.sv
// Purpose: CAN bus seen through a transceiver, wired-AND of all nodes
// Assumes: Dominant is 0 on node_tx_in, other_dom_in is 1 while another node drives dominant
// Notes: A small loop delay stands for the transceiver round trip
`timescale 1ns/1ps
module cmb_can_bus (
   input wire logic node_tx_in,
   input wire logic other_dom_in,
   output logic bus_rx_out
);
   // Recessive unless some node pulls dominant, so an idle bus reads 1
   assign #2 bus_rx_out = node_tx_in & ~other_dom_in;
endmodule // cmb_can_bus

// File: tb_top.sv
// Purpose: Self-checking bench for the message buffering block
// Assumes: Bench plays host and protocol engine, bus model plays the wire
// Notes: Inputs move 1 ns after the rising edge
`timescale 1ns/1ps
`include "cmb_params.svh"
module tb_top;
   logic clk = 0, rst = 1, rxp, lb = 0, etx = 1, txs = 0, txd = 0, rbwe = 0;
   logic rfok = 0, racc = 0, twr = 0, tpwr = 0, rien = 1, oien = 1, odom = 0, arbl = 0;
   logic [5:0] gpi = 0, gpd = 0, gpr = 0, gpo, gpoe;
   logic [3:0] tri_ = 0, rbi = 0, twi = 0, fgi = 0;
   logic [7:0] rb = 0, twd = 0, tpr = 0, prd, trd, fgd;
   logic [1:0] twb = 0, fclr = 0, tsel, flg;
   logic [2:0] trs = 0, temp;
   logic txpin, erx, treq, acken, rint, oint;
   int bad_count = 0, checks_done = 0, cycles = 0;
   always #20 clk = ~clk;
   cmb_can_bus u_cmb_can_bus (.node_tx_in(txpin), .other_dom_in(odom), .bus_rx_out(rxp));
   cmb_msg_buffer u_cmb_msg_buffer (.core_clk_in(clk), .rst_in(rst),
      .bus_receive_pin_in(rxp), .bus_transmit_pin_out(txpin), .gp_pin_in(gpi),
      .gp_pin_out(gpo), .gp_pin_oe_n_out(gpoe), .gp_data_in(gpd), .gp_dir_in(gpr),
      .port_read_out(prd), .loopback_in(lb), .engine_rx_bit_out(erx),
      .engine_tx_bit_in(etx), .tx_request_out(treq), .tx_buf_sel_out(tsel),
      .tx_start_in(txs), .tx_done_in(txd), .arb_lost_in(arbl), .tx_rd_idx_in(tri_),
      .tx_rd_data_out(trd), .rx_byte_we_in(rbwe), .rx_byte_idx_in(rbi), .rx_byte_in(rb),
      .rx_frame_ok_in(rfok), .rx_accept_in(racc), .rx_ack_en_out(acken),
      .tx_wr_in(twr), .tx_wr_buf_in(twb), .tx_wr_idx_in(twi), .tx_wr_data_in(twd),
      .tx_prio_wr_in(tpwr), .tx_prio_in(tpr), .tx_ready_set_in(trs), .tx_empty_out(temp),
      .fg_rd_idx_in(fgi), .fg_rd_data_out(fgd), .receiver_flag_register_out(flg),
      .flag_clr_in(fclr), .rx_int_en_in(rien), .ovr_int_en_in(oien),
      .rx_int_out(rint), .ovr_int_out(oint));
   // ****************************************************************
   // Shared helpers
   // ****************************************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask
   task automatic give_verdict();
      if (bad_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Thirteen bytes into background, then the good-frame strobe, spaced 3 apart
   task automatic frame(input logic [7:0] v, input logic acc);
      for (int i = 0; i < 13; i++) begin
         rbwe = 1;
         rbi = i[3:0];
         rb = v + i[7:0];
         cyc(1);
      end
      rbwe = 0;
      rfok = 1;
      racc = acc;
      cyc(1);
      rfok = 0;
      cyc(3);
   endtask
   task automatic load(input logic [1:0] b, input logic [7:0] p);
      twb = b;
      twr = 1;
      twd = 8'hA0 | {6'h00, b};
      cyc(1);
      twr = 0;
      tpwr = 1;
      tpr = p;
      cyc(1);
      tpwr = 0;
   endtask
   task automatic send_one(); // Start then complete the selected buffer
      txs = 1;
      cyc(1);
      txs = 0;
      txd = 1;
      cyc(1);
      txd = 0;
      cyc(1);
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      chk("tx pin", 8'h01, {7'h00, txpin});
      chk("flags", 8'h00, {6'h00, flg});
      chk("tx empty", 8'h07, {5'h00, temp});
      chk("ints", 8'h00, {6'h00, rint, oint});
      chk("ack idle", 8'h01, {7'h00, acken});
      chk("no request", 8'h00, {7'h00, treq});
   endtask
   task automatic t_pins();
      gpr = 6'h0F;
      gpd = 6'h2A;
      gpi = 6'h15;
      cyc(4);
      chk("gp out", 8'h2A, {2'h0, gpo});
      chk("gp oe_n", 8'h30, {2'h0, gpoe});
      chk("port high", 8'h1A, {2'h0, prd[7:2]});
      chk("port rx", 8'h01, {7'h00, prd[0]});
      chk("port tx", 8'h01, {7'h00, prd[1]});
   endtask
   task automatic t_tx();
      load(2'h0, 8'h1E);
      load(2'h1, 8'h0A);
      load(2'h2, 8'h14);
      trs = 3'h7;
      cyc(1);
      trs = 3'h0;
      cyc(1);
      chk("queued", 8'h00, {5'h00, temp});
      chk("best", 8'h01, {6'h00, tsel});
      cyc(1);
      chk("tx byte", 8'hA1, trd);
      txs = 1;
      cyc(1);
      txs = 0;
      etx = 0;
      cyc(4);
      chk("tx dominant", 8'h00, {7'h00, txpin});
      chk("pin echo", 8'h00, {7'h00, prd[0]});
      chk("ack own", 8'h00, {7'h00, acken});
      etx = 1;
      frame(8'h50, 1);
      chk("own flags", 8'h00, {6'h00, flg});
      txd = 1;
      cyc(1);
      txd = 0;
      cyc(1);
      chk("after done", 8'h02, {5'h00, temp});
      chk("rearb", 8'h01, {7'h00, treq});
      chk("next", 8'h02, {6'h00, tsel});
      send_one();
      lb = 1;
      txs = 1;
      cyc(1);
      txs = 0;
      etx = 0;
      cyc(1);
      chk("loop rx", 8'h00, {7'h00, erx});
      frame(8'h60, 1);
      chk("loop flag", 8'h01, {6'h00, flg});
      etx = 1;
      txd = 1;
      cyc(1);
      txd = 0;
      lb = 0;
      fclr = 2'h1;
      cyc(1);
      fclr = 0;
      cyc(3);
      chk("all empty", 8'h07, {5'h00, temp});
   endtask
   task automatic t_rx();
      frame(8'h10, 0);
      chk("rejected", 8'h00, {6'h00, flg});
      frame(8'h20, 1);
      chk("full", 8'h01, {6'h00, flg});
      chk("rx int", 8'h01, {7'h00, rint});
      fgi = 4'hC;
      cyc(1);
      chk("fg last", 8'h2C, fgd);
      frame(8'h30, 1);
      chk("held fg", 8'h2C, fgd);
      frame(8'h40, 1);
      chk("overrun", 8'h03, {6'h00, flg});
      chk("ovr int", 8'h01, {7'h00, oint});
      oien = 0;
      cyc(1);
      chk("ovr masked", 8'h00, {7'h00, oint});
      oien = 1;
      fclr = 2'h1;
      cyc(1);
      fclr = 0;
      cyc(3);
      chk("second", 8'h3C, fgd);
      chk("refill", 8'h03, {6'h00, flg});
      fclr = 2'h3;
      cyc(1);
      fclr = 0;
      cyc(2);
      chk("cleared", 8'h00, {6'h00, flg});
   endtask
   // Lost arbitration keeps the buffer queued and the winner is received
   task automatic t_arb();
      trs = 3'h1;
      cyc(1);
      trs = 3'h0;
      txs = 1;
      cyc(1);
      txs = 0;
      arbl = 1;
      cyc(1);
      arbl = 0;
      cyc(1);
      chk("lost queued", 8'h06, {5'h00, temp});
      chk("lost rearb", 8'h01, {7'h00, treq});
      chk("ack as rx", 8'h01, {7'h00, acken});
      frame(8'h70, 1);
      chk("winner", 8'h01, {6'h00, flg});
      chk("winner fg", 8'h7C, fgd);
      rien = 0;
      cyc(1);
      chk("rx masked", 8'h00, {7'h00, rint});
      rien = 1;
      send_one();
      fclr = 2'h1;
      cyc(1);
      fclr = 0;
      cyc(2);
      chk("arb done", 8'h07, {5'h00, temp});
      chk("arb flags", 8'h00, {6'h00, flg});
   endtask
   // Hang guard: far beyond the 190 cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin
      cyc(20);
      rst = 0;
      cyc(1);
      t_reset();
      t_pins();
      t_tx();
      t_rx();
      t_arb();
      give_verdict();
   end
endmodule // tb_top
